// >>> src/pofs_phy_init.sv
// Host sleep, wake and rate-change states plus device reset and COMINIT states.
module pofs_phy_init #(
   parameter int unsigned COMINIT_LIMIT = pofs_pkg::COMINIT_LIMIT_CYC,
   parameter bit ASYNC_RECOVERY = 1'b1
) (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic sleep_req_in,
   input wire logic phy_ready_in,
   input wire logic rate_done_in,
   input wire logic sync_done_in,
   input wire logic pwr_seq_done_in,
   input wire logic comwake_det_in,
   input wire logic comreset_det_in,
   output logic [2:0] host_state_out,
   output logic host_tx_quiet_out,
   output logic host_tx_invalid_out,
   output logic host_comwake_burst_out,
   output logic host_rx_relock_out,
   output logic wake_owed_flag_out,
   output logic host_wake_remote_out,
   output logic [1:0] dev_state_out,
   output logic dev_tx_quiet_out,
   output logic dev_cominit_burst_out
);

   // Pin synchronisers: three stages, a change counts once stages two and three agree.
   logic [pofs_pkg::SYNC_W-1:0] raw_in;
   logic [pofs_pkg::SYNC_W-1:0] s1_q, s2_q, s3_q, filt_q;
   assign raw_in = {comreset_det_in, comwake_det_in};
   genvar gi;
   generate
      for (gi = 0; gi < pofs_pkg::SYNC_W; gi++) begin : g_sync
         always_ff @(posedge ref_clk_in or posedge reset_in) begin
            if (reset_in) begin
               s1_q[gi] <= 1'b0;
               s2_q[gi] <= 1'b0;
               s3_q[gi] <= 1'b0;
               filt_q[gi] <= 1'b0;
            end else begin
               s1_q[gi] <= raw_in[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               filt_q[gi] <= (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : filt_q[gi];
            end
         end
      end
   endgenerate

   wire comwake_f = filt_q[pofs_pkg::SYNC_WAKE];
   wire comreset_f = filt_q[pofs_pkg::SYNC_RESET];

   // ---------------- Host side ----------------
   pofs_pkg::pofs_host_state_t host_q, host_d;
   logic wake_seen_q, wake_owed_q, relock_q;
   logic wstart_q;
   logic [pofs_pkg::BURST_NUM_W-1:0] inv_cnt_q;
   logic wburst, wbusy, wdone;

   wire h_sleep = (host_q == pofs_pkg::HOST_SLEEP);
   wire h_wsend = (host_q == pofs_pkg::HOST_WAKE_SEND);
   wire h_wend = (host_q == pofs_pkg::HOST_WAIT_WAKE_END);
   wire h_rate = (host_q == pofs_pkg::HOST_RATE_CHANGE);
   wire enter_sleep = !h_sleep && (host_d == pofs_pkg::HOST_SLEEP);
   // Remote wake seen so far, including one arriving in this very cycle.
   wire wake_seen = wake_seen_q | (h_sleep & comwake_f);
   wire inv_window = h_rate && (inv_cnt_q < pofs_pkg::BURST_NUM_W'(pofs_pkg::INVALID_MAX_CYC));
   wire wstart = h_wsend && !wstart_q;

   // Host next state; sleep exit needs both the link release and a recovered phy.
   always_comb begin
      host_d = host_q;
      unique case (host_q)
         pofs_pkg::HOST_IDLE: begin
            if (sleep_req_in) host_d = pofs_pkg::HOST_SLEEP;
         end
         pofs_pkg::HOST_SLEEP: begin
            if (sleep_req_in || !phy_ready_in) host_d = pofs_pkg::HOST_SLEEP;
            else if (wake_seen) host_d = pofs_pkg::HOST_WAIT_WAKE_END;
            else host_d = pofs_pkg::HOST_WAKE_SEND;
         end
         pofs_pkg::HOST_WAKE_SEND: begin
            if (wdone) host_d = pofs_pkg::HOST_WAIT_WAKE_END;
         end
         pofs_pkg::HOST_WAIT_WAKE_END: begin
            if (!comwake_f) host_d = pofs_pkg::HOST_RATE_CHANGE;
         end
         pofs_pkg::HOST_RATE_CHANGE: begin
            if (rate_done_in) host_d = pofs_pkg::HOST_SEND_SYNC;
         end
         pofs_pkg::HOST_SEND_SYNC: begin
            if (sync_done_in) host_d = pofs_pkg::HOST_IDLE;
         end
         default: host_d = pofs_pkg::HOST_IDLE;
      endcase
   end

   // Host registers; the seen flag is cleared only on entry to sleep, and that clear wins over a set.
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         host_q <= pofs_pkg::HOST_IDLE;
         wake_seen_q <= 1'b0;
         wake_owed_q <= 1'b0;
         relock_q <= 1'b0;
         wstart_q <= 1'b0;
         inv_cnt_q <= '0;
      end else begin
         host_q <= host_d;
         wake_seen_q <= enter_sleep ? 1'b0 : wake_seen;
         wake_owed_q <= (h_sleep && ASYNC_RECOVERY) ||
                        (wake_owed_q && host_d != pofs_pkg::HOST_SEND_SYNC);
         relock_q <= h_rate && rate_done_in;
         wstart_q <= h_wsend;
         inv_cnt_q <= h_rate ? (inv_window ? inv_cnt_q + 1'b1 : inv_cnt_q) : '0;
      end
   end

   pofs_burst_gen #(
      .BURSTS(pofs_pkg::COMWAKE_BURSTS),
      .ON_CYC(pofs_pkg::BURST_ON_CYC),
      .GAP_CYC(pofs_pkg::COMWAKE_GAP_CYC)
   ) u_wake_gen (
      .ref_clk_in(ref_clk_in),
      .reset_in(reset_in),
      .start_in(wstart),
      .burst_out(wburst),
      .busy_out(wbusy),
      .done_out(wdone)
   );

   // Host line: quiet in sleep, never quiet while the rate changes.
   assign host_state_out = host_q;
   assign host_tx_quiet_out = h_sleep || h_wend || (h_wsend && !wburst);
   assign host_tx_invalid_out = inv_window;
   assign host_comwake_burst_out = wburst;
   assign host_rx_relock_out = relock_q;
   assign wake_owed_flag_out = wake_owed_q;
   assign host_wake_remote_out = wake_seen_q;

   // ---------------- Device side ----------------
   // Raw COMRESET joins power-on reset as an asynchronous reset; it reaches a data input
   // only at the first synchroniser stage, so a glitch can only push the machine back to its reset state.
   wire dev_arst = reset_in | comreset_det_in;
   pofs_pkg::pofs_dev_state_t dev_q, dev_d;
   logic dstart_q;
   logic [pofs_pkg::WAIT_W-1:0] wait_q;
   logic [pofs_pkg::BURST_NUM_W-1:0] bseen_q;
   logic dburst, dburst_q, dbusy, ddone;

   wire d_reset = (dev_q == pofs_pkg::DEV_RESET);
   wire d_init = (dev_q == pofs_pkg::DEV_INIT_SEND);
   wire wait_hit = (wait_q >= pofs_pkg::WAIT_W'(COMINIT_LIMIT - 1));
   // Send once power-up is done, or at the latest when the wait runs out.
   wire dstart = d_init && !dstart_q && (pwr_seq_done_in || wait_hit);

   // Device next state; the synchronised COMRESET overrides every other term.
   always_comb begin
      dev_d = dev_q;
      unique case (dev_q)
         pofs_pkg::DEV_RESET: begin
            if (!comreset_f) dev_d = pofs_pkg::DEV_INIT_SEND;
         end
         pofs_pkg::DEV_INIT_SEND: begin
            if (ddone) dev_d = pofs_pkg::DEV_WAIT_WAKE;
         end
         pofs_pkg::DEV_WAIT_WAKE: dev_d = pofs_pkg::DEV_WAIT_WAKE;
         default: dev_d = pofs_pkg::DEV_RESET;
      endcase
      if (comreset_f) dev_d = pofs_pkg::DEV_RESET;
   end

   // Device registers, all thrown back by either reset source.
   always_ff @(posedge ref_clk_in or posedge dev_arst) begin
      if (dev_arst) begin
         dev_q <= pofs_pkg::DEV_RESET;
         dstart_q <= 1'b0;
         wait_q <= '0;
         bseen_q <= '0;
         dburst_q <= 1'b0;
      end else begin
         dev_q <= dev_d;
         dstart_q <= d_init && (dstart_q || dstart);
         wait_q <= (d_init && !dstart_q && !wait_hit) ? wait_q + 1'b1 : (d_init ? wait_q : '0);
         bseen_q <= !d_init ? '0 : (dburst && !dburst_q) ? bseen_q + 1'b1 : bseen_q;
         dburst_q <= dburst;
      end
   end

   pofs_burst_gen #(
      .BURSTS(pofs_pkg::COMINIT_BURSTS),
      .ON_CYC(pofs_pkg::BURST_ON_CYC),
      .GAP_CYC(pofs_pkg::COMINIT_GAP_CYC)
   ) u_init_gen (
      .ref_clk_in(ref_clk_in),
      .reset_in(dev_arst),
      .start_in(dstart),
      .burst_out(dburst),
      .busy_out(dbusy),
      .done_out(ddone)
   );

   assign dev_state_out = dev_q;
   assign dev_tx_quiet_out = !dburst;
   assign dev_cominit_burst_out = dburst;

   // ---------------- Checks ----------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);

   sequence s_sleep_release;
      h_sleep && !sleep_req_in && phy_ready_in;
   endsequence

   sequence s_rate_done;
      h_rate && rate_done_in;
   endsequence

   a_sleep_quiet: assert property (
      h_sleep |-> host_tx_quiet_out ##1 (wake_owed_q || !ASYNC_RECOVERY))
      else $error("sleep not quiet or wake owed flag not set");
   a_wake_send_path: assert property (
      s_sleep_release and !wake_seen |=> h_wsend ##1 wburst)
      else $error("sleep exit without remote wake did not start wake send");
   a_wake_end_path: assert property (s_sleep_release and wake_seen |=> h_wend)
      else $error("sleep exit after remote wake went the wrong way");
   a_sleep_hold: assert property (
      h_sleep && (sleep_req_in || !phy_ready_in) |=> h_sleep)
      else $error("sleep left while requested or phy not ready");
   a_wake_seen_kept: assert property (h_sleep && comwake_f ##1 h_sleep |-> wake_seen_q)
      else $error("remote wake during sleep was not recorded");
   a_rate_quiet: assert property (h_rate |-> !host_tx_quiet_out)
      else $error("line quiet during rate change");
   a_rate_exit: assert property (
      s_rate_done |=> host_q == pofs_pkg::HOST_SEND_SYNC && host_rx_relock_out)
      else $error("rate change did not end in sync with relock");
   a_rate_stay: assert property (h_rate && !rate_done_in |=> h_rate)
      else $error("rate change left before completion");
   a_invalid_short: assert property (
      $rose(host_tx_invalid_out) |-> ##1 !host_tx_invalid_out)
      else $error("invalid signalling longer than allowed");
   a_reset_force: assert property (disable iff (reset_in) comreset_f |=> d_reset)
      else $error("COMRESET did not force device reset");
   a_reset_async: assert property (
      disable iff (reset_in) comreset_det_in |-> d_reset && dev_tx_quiet_out)
      else $error("device not in reset while COMRESET present");
   // The edge that releases a reset still runs the reset branch, so it is left out.
   a_reset_exit: assert property (
      disable iff (dev_arst) d_reset && !comreset_f && !dev_arst |=> d_init)
      else $error("device did not leave reset for COMINIT send");
   a_init_deadline: assert property (
      disable iff (dev_arst) d_init && !dstart_q |-> wait_q < pofs_pkg::WAIT_W'(COMINIT_LIMIT))
      else $error("COMINIT not started within the deadline");
   a_six_bursts: assert property (
      disable iff (dev_arst) d_init && ddone |->
      bseen_q == pofs_pkg::BURST_NUM_W'(pofs_pkg::COMINIT_BURSTS)
      ##1 dev_q == pofs_pkg::DEV_WAIT_WAKE)
      else $error("COMINIT burst count wrong or no move to wake wait");

endmodule

// >>> src/pofs_pkg.sv
// Shared constants and state types for the link power and init state machines.
package pofs_pkg;

   // Clock and derived timing.
   localparam int CLK_PERIOD_NS = 40;
   localparam int INVALID_MAX_NS = 53;
   // A longest time rounds down, but never below one cycle.
   localparam int INVALID_MAX_CYC = (INVALID_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
                                    INVALID_MAX_NS / CLK_PERIOD_NS;
   localparam int COMINIT_LIMIT_MS = 10;
   localparam int COMINIT_LIMIT_CYC = COMINIT_LIMIT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int WAIT_W = 18;

   // Out-of-band burst shaping, in clock cycles.
   localparam int COMINIT_BURSTS = 6;
   localparam int COMWAKE_BURSTS = 6;
   localparam int BURST_ON_CYC = 3;
   localparam int COMINIT_GAP_CYC = 8;
   localparam int COMWAKE_GAP_CYC = 3;
   localparam int BURST_CNT_W = 8;
   localparam int BURST_NUM_W = 4;

   // Input synchroniser layout.
   localparam int SYNC_W = 2;
   localparam int SYNC_WAKE = 0;
   localparam int SYNC_RESET = 1;

   typedef enum logic [2:0] {
      HOST_IDLE = 3'h0,
      HOST_SLEEP = 3'h1,
      HOST_WAKE_SEND = 3'h2,
      HOST_WAIT_WAKE_END = 3'h3,
      HOST_RATE_CHANGE = 3'h4,
      HOST_SEND_SYNC = 3'h5
   } pofs_host_state_t;

   typedef enum logic [1:0] {
      DEV_RESET = 2'h0,
      DEV_INIT_SEND = 2'h1,
      DEV_WAIT_WAKE = 2'h2
   } pofs_dev_state_t;

endpackage

// >>> src/pofs_burst_gen.sv
// Out-of-band burst train generator: a fixed number of bursts with fixed gaps.
module pofs_burst_gen #(
   parameter int BURSTS = 6,
   parameter int ON_CYC = 3,
   parameter int GAP_CYC = 8
) (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic start_in,
   output logic burst_out,
   output logic busy_out,
   output logic done_out
);

   logic busy_q, busy_d;
   logic on_q, on_d;
   logic done_q, done_d;
   logic [pofs_pkg::BURST_CNT_W-1:0] cnt_q, cnt_d;
   logic [pofs_pkg::BURST_NUM_W-1:0] num_q, num_d;

   wire cnt_zero = (cnt_q == '0);
   wire last_burst = (num_q == pofs_pkg::BURST_NUM_W'(BURSTS - 1));

   // Next-state: the train ends after the gap of the last burst, so line settles.
   always_comb begin
      busy_d = busy_q;
      on_d = on_q;
      cnt_d = cnt_q;
      num_d = num_q;
      done_d = 1'b0;
      if (!busy_q) begin
         if (start_in) begin
            busy_d = 1'b1;
            on_d = 1'b1;
            num_d = '0;
            cnt_d = pofs_pkg::BURST_CNT_W'(ON_CYC - 1);
         end
      end else if (!cnt_zero) begin
         cnt_d = cnt_q - 1'b1;
      end else if (on_q) begin
         on_d = 1'b0;
         cnt_d = pofs_pkg::BURST_CNT_W'(GAP_CYC - 1);
      end else if (last_burst) begin
         busy_d = 1'b0;
         done_d = 1'b1;
      end else begin
         num_d = num_q + 1'b1;
         on_d = 1'b1;
         cnt_d = pofs_pkg::BURST_CNT_W'(ON_CYC - 1);
      end
   end

   // Train registers.
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         busy_q <= 1'b0;
         on_q <= 1'b0;
         done_q <= 1'b0;
         cnt_q <= '0;
         num_q <= '0;
      end else begin
         busy_q <= busy_d;
         on_q <= on_d;
         done_q <= done_d;
         cnt_q <= cnt_d;
         num_q <= num_d;
      end
   end

   assign burst_out = busy_q & on_q;
   assign busy_out = busy_q;
   assign done_out = done_q;

endmodule

// >>> tb/pofs_far_model.sv
// Behavioural remote phy: out-of-band detections and the line-rate change answer.
module pofs_far_model (
   input wire logic ref_clk_in,
   input wire logic [2:0] host_state_in,
   output logic comwake_det_out,
   output logic comreset_det_out,
   output logic rate_done_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int rate_lat = 0;
   int rate_cnt = 0;
   initial begin
      comwake_det_out = 1'b0;
      comreset_det_out = 1'b0;
      rate_done_out = 1'b0;
   end
   // The answer waits rate_lat cycles, so the bench can play a prompt or a slow remote end.
   always @(posedge ref_clk_in) begin
      if (host_state_in == 3'h4) begin
         rate_cnt <= rate_cnt + 1;
      end else begin
         rate_cnt <= 0;
      end
      rate_done_out <= (host_state_in == 3'h4) && (rate_cnt >= rate_lat);
   end
   // A remote wake train is seen as one level for n cycles.
   task automatic send_comwake(input int n);
      @(posedge ref_clk_in);
      comwake_det_out <= 1'b1;
      repeat (n) @(posedge ref_clk_in);
      comwake_det_out <= 1'b0;
   endtask
   // The reset detection is an unclocked pin, but the bench still moves it on a rising edge.
   task automatic set_comreset(input logic v);
      @(posedge ref_clk_in);
      comreset_det_out <= v;
   endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the link sleep, rate change and device reset machines.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LIMIT = 50;
   logic ref_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic sleep_req = 1'b0;
   logic phy_ready = 1'b1;
   logic sync_done = 1'b0;
   logic pwr_done = 1'b0;
   logic comwake_det;
   logic comreset_det;
   logic rate_done;
   logic [2:0] host_state;
   logic [1:0] dev_state;
   logic host_quiet, host_invalid, wake_burst, relock, wake_owed, wake_remote;
   logic dev_quiet, init_burst;
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;
   int b, f;

   pofs_far_model far (.ref_clk_in(ref_clk_in), .host_state_in(host_state),
      .comwake_det_out(comwake_det), .comreset_det_out(comreset_det),
      .rate_done_out(rate_done));

   pofs_phy_init #(.COMINIT_LIMIT(LIMIT)) uut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
      .sleep_req_in(sleep_req), .phy_ready_in(phy_ready), .rate_done_in(rate_done),
      .sync_done_in(sync_done), .pwr_seq_done_in(pwr_done), .comwake_det_in(comwake_det),
      .comreset_det_in(comreset_det), .host_state_out(host_state),
      .host_tx_quiet_out(host_quiet), .host_tx_invalid_out(host_invalid),
      .host_comwake_burst_out(wake_burst), .host_rx_relock_out(relock),
      .wake_owed_flag_out(wake_owed), .host_wake_remote_out(wake_remote),
      .dev_state_out(dev_state), .dev_tx_quiet_out(dev_quiet),
      .dev_cominit_burst_out(init_burst));

   always #20 ref_clk_in = ~ref_clk_in;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // A hang counts against the run instead of stalling it.
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         $display("mismatch at %0t: run limit reached", $time);
         close_out();
      end
   end

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge ref_clk_in);
         #1;
      end
   endtask

   // Waits for a host state while counting wake bursts on the way.
   task automatic wait_host(input logic [2:0] s, input int lim, output int bursts);
      logic prev;
      prev = wake_burst;
      bursts = 0;
      for (int i = 0; i < lim && host_state !== s; i++) begin
         tick(1);
         if (wake_burst === 1'b1 && prev !== 1'b1) bursts++;
         prev = wake_burst;
      end
   endtask

   // Same for the device side; first holds the cycle of the first burst.
   task automatic wait_dev(input logic [1:0] s, input int lim, output int bursts,
                           output int first);
      logic prev;
      prev = init_burst;
      bursts = 0;
      first = lim;
      for (int i = 0; i < lim && dev_state !== s; i++) begin
         tick(1);
         if (init_burst === 1'b1 && prev !== 1'b1) begin
            if (bursts == 0) first = i;
            bursts++;
         end
         prev = init_burst;
      end
   endtask

   task automatic t_dev_init();
      wait_dev(2'h1, 10, b, f);
      check(dev_state, 8'h1);
      wait_dev(2'h2, LIMIT + 200, b, f);
      check(dev_state, 8'h2);
      check(b, 8'h6);
      check(f <= LIMIT + 2, 8'h1);
      check(dev_quiet, 8'h1);
      $display("test dev_init done");
   endtask

   task automatic t_comreset();
      far.set_comreset(1'b1);
      #1;
      check(dev_state, 8'h0);
      check(dev_quiet, 8'h1);
      tick(6);
      check(dev_state, 8'h0);
      far.set_comreset(1'b0);
      @(posedge ref_clk_in);
      pwr_done <= 1'b1;
      #1;
      wait_dev(2'h1, 8, b, f);
      check(dev_state, 8'h1);
      tick(2);
      check(init_burst, 8'h1);
      // A reset in mid-burst must cut the burst, not let it finish.
      far.set_comreset(1'b1);
      #1;
      check(dev_state, 8'h0);
      check(init_burst, 8'h0);
      far.set_comreset(1'b0);
      wait_dev(2'h2, 200, b, f);
      check(b, 8'h6);
      $display("test comreset done");
   endtask

   task automatic t_sleep_local();
      far.rate_lat = 10;
      @(posedge ref_clk_in);
      phy_ready <= 1'b0;
      sleep_req <= 1'b1;
      #1;
      tick(1);
      check(host_state, 8'h1);
      check(host_quiet, 8'h1);
      tick(2);
      check(wake_owed, 8'h1);
      check(host_state, 8'h1);
      @(posedge ref_clk_in);
      sleep_req <= 1'b0;
      #1;
      tick(4);
      check(host_state, 8'h1);
      @(posedge ref_clk_in);
      phy_ready <= 1'b1;
      #1;
      wait_host(3'h3, 100, b);
      check(host_state, 8'h3);
      check(b, 8'h6);
      check(wake_remote, 8'h0);
      wait_host(3'h4, 10, b);
      check(host_invalid, 8'h1);
      check(host_quiet, 8'h0);
      tick(1);
      check(host_invalid, 8'h0);
      check(host_quiet, 8'h0);
      tick(3);
      check(host_state, 8'h4);
      wait_host(3'h5, 20, b);
      check(host_state, 8'h5);
      check(relock, 8'h1);
      check(wake_owed, 8'h0);
      tick(1);
      check(relock, 8'h0);
      @(posedge ref_clk_in);
      sync_done <= 1'b1;
      #1;
      $display("test sleep_local done");
   endtask

   task automatic t_sleep_remote();
      far.rate_lat = 0;
      @(posedge ref_clk_in);
      sync_done <= 1'b0;
      sleep_req <= 1'b1;
      #1;
      wait_host(3'h1, 4, b);
      check(host_state, 8'h1);
      far.send_comwake(8);
      tick(4);
      @(posedge ref_clk_in);
      sleep_req <= 1'b0;
      #1;
      wait_host(3'h3, 10, b);
      check(host_state, 8'h3);
      check(wake_remote, 8'h1);
      wait_host(3'h5, 20, b);
      check(host_state, 8'h5);
      $display("test sleep_remote done");
   endtask

   task automatic t_por();
      @(posedge ref_clk_in);
      reset_in <= 1'b1;
      #1;
      check(dev_state, 8'h0);
      check(host_state, 8'h0);
      tick(2);
      check(dev_state, 8'h0);
      @(posedge ref_clk_in);
      reset_in <= 1'b0;
      #1;
      wait_dev(2'h1, 10, b, f);
      check(dev_state, 8'h1);
      $display("test por done");
   endtask

   initial begin
      repeat (5) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      #1;
      t_dev_init();
      t_comreset();
      t_sleep_local();
      t_sleep_remote();
      t_por();
      close_out();
   end
endmodule
